// ==== core/cdt_timer.sv ====
// count-down timer: control, counter, register port, interrupts
// assumes a synchronous register port and pin inputs sync to mclk
// assumes stopWake comes from the external wake logic while stopped
// wait mode is no input: the timer simply keeps running then
`include "cdt_cfg.svh"

module cdt_timer #(
    parameter int STAB_CYC = `CDT_STAB_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // timer pin and internal clock enable
    input wire logic timerPin,
    input wire logic intClkEn,
    // power modes
    input wire logic stopMode,
    input wire logic stopWake,
    // cpu request and block interrupt
    output logic timerReq,
    output logic irq
);

    cdt_pkg::cdt_req_s req;
    cdt_pkg::cdt_pwr_e pwr_q;
    logic [7:0] count_q;
    logic [7:0] rdata_q;
    logic flag_q;
    logic reqMask_q;
    logic [1:0] src_q;
    logic [2:0] psel_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic [15:0] stab_q;
    logic srcTick;
    logic cntTick;
    logic pclr;
    logic wrCount;
    logic wrCtrl;
    logic hitZero;
    logic stopDone;
    logic runTick;
    logic wrStat;
    logic wrMask;
    logic flag_d;
    logic [7:0] count_d;
    logic [7:0] rdata_d;
    logic [15:0] stab_d;
    logic [1:0] irqEvt;
    logic [1:0] irqClr;
    logic [1:0] irqStat_d;
    cdt_pkg::cdt_pwr_e pwr_d;

    // ****************************************************************
    // register decode
    // ****************************************************************
    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    // single decode used by every write path
    function automatic logic hit(input cdt_pkg::cdt_req_s r,
        input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    assign wrCount = hit(req, `CDT_ADDR_COUNT);
    assign wrCtrl = hit(req, `CDT_ADDR_CTRL);
    assign pclr = wrCtrl && req.wdata[`CDT_BIT_PCLR]; // R9 R19
    assign wrStat = hit(req, `CDT_ADDR_IRQ_STAT);
    assign wrMask = hit(req, `CDT_ADDR_IRQ_MASK);

    // control byte as software sees it; the clear bit never reads back
    function automatic logic [7:0] ctrl_image(input logic f,
        input logic m, input logic [1:0] s, input logic [2:0] p);
        ctrl_image = {f, m, s, 1'b0, p}; // R9 R19
    endfunction : ctrl_image

    // ****************************************************************
    // clock source
    // ****************************************************************
    always_comb
    begin
        case (cdt_pkg::cdt_src_e'(src_q)) // R11
            cdt_pkg::CDT_SRC_INT: srcTick = intClkEn;
            cdt_pkg::CDT_SRC_AND: srcTick = intClkEn && timerPin;
            cdt_pkg::CDT_SRC_OFF: srcTick = 1'b0;
            cdt_pkg::CDT_SRC_PIN: srcTick = timerPin;
            default: srcTick = 1'b0;
        endcase
    end

    // counting frozen outside the run state only
    assign runTick = srcTick && (pwr_q == cdt_pkg::CDT_RUN); // R15

    // prescaler; its count is hidden from software
    cdt_prescaler #(
        .WIDTH(7)
    ) uPresc (
        .mclk(mclk),
        .rst_n(rst_n),
        .tickIn(runTick),
        .clear(pclr),
        .sel(psel_q),
        .tickOut(cntTick)
    );

    // ****************************************************************
    // stop-mode sequencing
    // ****************************************************************
    assign stopDone = (pwr_q == cdt_pkg::CDT_STAB) &&
        (stab_q == 16'(STAB_CYC - 1));

    // next power state; an unknown code falls back to running
    always_comb
    begin
        pwr_d = pwr_q;
        case (pwr_q)
            cdt_pkg::CDT_RUN:
                if (stopMode)
                    pwr_d = cdt_pkg::CDT_STOPPED; // R15
            cdt_pkg::CDT_STOPPED:
                if (stopWake)
                    pwr_d = cdt_pkg::CDT_STAB;
            cdt_pkg::CDT_STAB:
                if (stopDone)
                    pwr_d = cdt_pkg::CDT_RUN; // R16
            default:
                pwr_d = cdt_pkg::CDT_RUN;
        endcase
    end

    // power state register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pwr_q <= cdt_pkg::CDT_RUN;
        else
            pwr_q <= pwr_d;
    end

    // stabilisation delay count, idle at zero outside the delay
    always_comb
    begin
        stab_d = 16'h0000;
        if (pwr_q == cdt_pkg::CDT_STAB)
            stab_d = stab_q + 16'h0001;
    end

    // stabilisation delay register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            stab_q <= '0;
        else
            stab_q <= stab_d;
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    assign hitZero = (cntTick && !wrCount && count_q == 8'h01) || stopDone;

    // write wins over a tick in the same cycle so the load is exact;
    // the stop exit clear wins over both
    always_comb
    begin
        count_d = count_q;
        if (stopDone)
            count_d = 8'h00; // R16
        else if (wrCount)
            count_d = req.wdata; // R18 R1
        else if (cntTick)
            count_d = count_q - 8'h01; // R1 R5 R18
    end

    // count register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= `CDT_RST_COUNT; // R17
        else
            count_q <= count_d;
    end

    // ****************************************************************
    // control register
    // ****************************************************************
    // request mask; reset leaves the request closed
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reqMask_q <= 1'b1; // R13
        else if (wrCtrl)
            reqMask_q <= req.wdata[`CDT_BIT_MASK]; // R13
    end

    // clock source pair
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            src_q <= 2'b00; // R12
        else if (wrCtrl)
            src_q <= req.wdata[`CDT_BIT_EXTSEL:`CDT_BIT_PINEN]; // R11
    end

    // prescale select
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            psel_q <= `CDT_RST_PSEL; // R14
        else if (wrCtrl)
            psel_q <= req.wdata[2:0]; // R14
    end

    // ****************************************************************
    // zero flag and cpu request
    // ****************************************************************
    // sticky zero flag; a new zero in the clearing cycle keeps it set
    always_comb
    begin
        flag_d = flag_q;
        if (hitZero)
            flag_d = 1'b1; // R2 R7
        else if (wrCtrl && !req.wdata[`CDT_BIT_FLAG])
            flag_d = 1'b0; // R2 R7
    end

    // flag register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            flag_q <= 1'b0; // R2
        else
            flag_q <= flag_d;
    end

    // mask touches only the request, never counting or the flag
    assign timerReq = flag_q && !reqMask_q; // R3 R13 R4

    // ****************************************************************
    // block interrupt status: bit0 zero reached, bit1 stop exit
    // ****************************************************************
    assign irqEvt = {stopDone, hitZero};
    assign irqClr = wrStat ? req.wdata[1:0] : 2'b00;

    // per-source next value; an event in the clearing cycle wins
    for (genvar i = 0; i < 2; i++)
    begin : gStat
        assign irqStat_d[i] = irqEvt[i] || (irqStat_q[i] && !irqClr[i]);
    end

    // status register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irqStat_q <= 2'b00;
        else
            irqStat_q <= irqStat_d;
    end

    // ****************************************************************
    // block interrupt mask and output
    // ****************************************************************
    // mask of the same layout, one enables
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irqMask_q <= `CDT_RST_IRQ_MASK;
        else if (wrMask)
            irqMask_q <= req.wdata[1:0];
    end

    assign irq = |(irqStat_q & irqMask_q);

    // ****************************************************************
    // read path
    // ****************************************************************
    // read mux; unmapped reads and idle cycles give zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (req.rd)
            case (req.addr)
                `CDT_ADDR_COUNT: rdata_d = count_q; // R6 R17
                `CDT_ADDR_CTRL: rdata_d = ctrl_image(flag_q, reqMask_q,
                    src_q, psel_q); // R9 R19
                `CDT_ADDR_IRQ_STAT: rdata_d = {6'h00, irqStat_q};
                `CDT_ADDR_IRQ_MASK: rdata_d = {6'h00, irqMask_q};
                default: rdata_d = 8'h00;
            endcase
    end

    // count sampled at the strobe edge so it is steady in the data cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end

    assign regRdata = rdata_q;

endmodule : cdt_timer

// ==== shared/cdt_cfg.svh ====
// constants for the count-down timer with prescaler
// assumes a byte-wide register port and one 10 MHz clock
// Contract
// R1 - 8-bit counter, preset, decrements per prescaler pulse
// R2 - flag sets at zero, cleared reset or write-zero
// R3 - request only while flag set and mask clear
// R4 - cpu services request via timer vector
// R5 - counter keeps decrementing after zero
// R6 - counter reads never disturb counting
// R7 - flag sticky until software clears it
// R8 - 7-bit hidden prescaler tap clocks counter
// R9 - prescaler clear bit write-one, reads zero
// R10 - software clears prescaler on each new count
// R11 - clock select: internal, and-pin, off, pin
// R12 - reset clears both clock select bits
// R13 - mask resets to one, gates request only
// R14 - prescale field divides by two-power, reset 100
// R15 - halt in stop mode, run in wait
// R16 - stop exit clears counter, sets flag
// R17 - count register reads count, resets all ones
// R18 - write loads counter, zero wraps to ones
// R19 - bit 3 reads zero, zero write ignored
`ifndef CDT_CFG_SVH
`define CDT_CFG_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CDT_ADDR_COUNT 8'h08
`define CDT_ADDR_CTRL 8'h09
`define CDT_ADDR_IRQ_STAT 8'h0a
`define CDT_ADDR_IRQ_MASK 8'h0b

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define CDT_BIT_FLAG 7
`define CDT_BIT_MASK 6
`define CDT_BIT_EXTSEL 5
`define CDT_BIT_PINEN 4
`define CDT_BIT_PCLR 3
`define CDT_RST_COUNT 8'hff
`define CDT_RST_PSEL 3'h4
`define CDT_RST_IRQ_MASK 2'h0

// ****************************************************************
// timing
// ****************************************************************
`define CDT_CLK_HZ 10000000
`define CDT_STAB_NS 1000
`define CDT_STAB_CYC ((`CDT_STAB_NS * (`CDT_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ==== shared/cdt_pkg.sv ====
// types shared by the count-down timer files
// assumes the constants header sits beside it
package cdt_pkg;

    // clock source pair
    typedef enum logic [1:0]
    {
        CDT_SRC_INT = 2'b00,
        CDT_SRC_AND = 2'b01,
        CDT_SRC_OFF = 2'b10,
        CDT_SRC_PIN = 2'b11
    } cdt_src_e;

    // register port request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cdt_req_s;

    // stop-exit sequencing
    typedef enum logic [1:0]
    {
        CDT_RUN = 2'b00,
        CDT_STOPPED = 2'b01,
        CDT_STAB = 2'b10
    } cdt_pwr_e;

endpackage : cdt_pkg

// ==== core/cdt_prescaler.sv ====
// 7-bit prescaler with selectable tap
// assumes a one-cycle counting enable from the clock selector
`include "cdt_cfg.svh"

module cdt_prescaler #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic tickIn,
    input wire logic clear,
    input wire logic [2:0] sel,
    // output pulse
    output logic tickOut
);

    logic [WIDTH-1:0] div_q;
    logic [WIDTH:0] nextDiv;
    logic wrapAll;
    logic [WIDTH:0] tapMask;

    // ****************************************************************
    // divider
    // ****************************************************************
    // tap k pulses when the low k bits roll over, giving divide by 2^k
    assign nextDiv = {1'b0, div_q} + {{WIDTH{1'b0}}, 1'b1};
    // one bit wider so the top tap mask cannot overflow
    assign tapMask = ({{WIDTH{1'b0}}, 1'b1} << sel)
        - {{WIDTH{1'b0}}, 1'b1};
    assign wrapAll = (div_q & tapMask[WIDTH-1:0]) == tapMask[WIDTH-1:0];
    assign tickOut = tickIn && !clear && wrapAll; // R8 R14

    // clear dominates; software cannot see or load the divider
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            div_q <= '0;
        else if (clear)
            div_q <= '0; // R9
        else if (tickIn)
            div_q <= nextDiv[WIDTH-1:0]; // R8
    end

endmodule : cdt_prescaler

// ==== verification/cdt_timer_properties.sv ====
// checker: register port and cpu request relations of the timer
// assumes it is bound onto cdt_timer, one clock domain mclk
module cdt_timer_properties #(
    parameter int STAB_CYC = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // pins and power modes
    input wire logic timerPin,
    input wire logic intClkEn,
    input wire logic stopMode,
    input wire logic stopWake,
    // requests
    input wire logic timerReq,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ******
    // sequences and properties
    // ******
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // bus tasks leave one idle cycle between write and read
    sequence s_load_read;
        regWr && regAddr == 8'h08 ##2 regRd && regAddr == 8'h08;
    endsequence
    sequence s_ctrl_read;
        regWr && regAddr == 8'h09 ##2 regRd && regAddr == 8'h09;
    endsequence
    a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    a_read_unmapped: assert property ($past(regRd) && ($past(regAddr) < 8'h08
        || $past(regAddr) > 8'h0b) |-> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_gap_bit: assert property (
        $past(regRd) && $past(regAddr) == 8'h09 |-> !regRdata[3])
        else $error("prescaler clear bit read as one");
    a_load_then_read: assert property (s_load_read |=>
        regRdata inside {$past(regWdata, 3), $past(regWdata, 3) - 8'h01})
        else $error("count read does not follow load");
    a_ctrl_readback: assert property (s_ctrl_read |=>
        ((regRdata ^ $past(regWdata, 3)) & 8'h77) == 8'h00)
        else $error("control fields not kept");
    a_mask_gates_req: assert property (
        regWr && regAddr == 8'h09 && regWdata[6] |=> !timerReq)
        else $error("request with mask set");
    a_req_matches_ctrl: assert property (regRd && regAddr == 8'h09 |=>
        (regRdata[7] && !regRdata[6]) == $past(timerReq))
        else $error("request differs from flag and mask");
    a_irq_mask_off: assert property (
        regWr && regAddr == 8'h0b && regWdata[1:0] == 2'b00 |=> !irq)
        else $error("irq with all sources masked");
endmodule : cdt_timer_properties

bind cdt_timer cdt_timer_properties #(.STAB_CYC(STAB_CYC)) u_props (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timerPin(timerPin), .intClkEn(intClkEn), .stopMode(stopMode),
    .stopWake(stopWake), .timerReq(timerReq), .irq(irq));

// ==== verification/cdt_cpu_model.sv ====
// cpu side model: takes the timer request between instructions
// assumes timerReq is a level, iBit is the core mask from the bench
module cdt_cpu_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // request and core mask
    input wire logic timerReq,
    input wire logic iBit,
    // count of serviced requests
    output logic [7:0] svcCnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_q;
    // three-cycle instructions; pending request seen only at the end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= 2'h0;
            svcCnt <= 8'h00;
        end
        else
        begin
            phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
            if (phase_q == 2'h2 && timerReq && !iBit)
                svcCnt <= svcCnt + 8'h01; // stands for stack and vector
        end
    end
endmodule : cdt_cpu_model

// ==== verification/tb_top.sv ====
// bench for the count-down timer with a cpu model on its request
// assumes the design, the cpu model and the checker compile first
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_n, regWr, regRd, timerPin, intClkEn;
    logic stopMode, stopWake, iBit, timerReq, irq;
    logic [7:0] regAddr, regWdata, regRdata, svcCnt, d, e, c;
    int error_cnt, samples_checked, seed, r;
    // short stabilisation count keeps the stop exit quick
    cdt_timer #(.STAB_CYC(2)) dut (.mclk(mclk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .timerPin(timerPin),
        .intClkEn(intClkEn), .stopMode(stopMode), .stopWake(stopWake),
        .timerReq(timerReq), .irq(irq));
    cdt_cpu_model cpu (.mclk(mclk), .rst_n(rst_n), .timerReq(timerReq),
        .iBit(iBit), .svcCnt(svcCnt));
    // 10 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ******
    // bus and check tasks
    // ******
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        v = regRdata;
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // prescaler phase is unknown, so one count either way is allowed
    task automatic near(input logic [7:0] got, input logic [7:0] exp);
        if ((got - exp) inside {8'h00, 8'h01, 8'hff})
            chk(got, got);
        else
            chk(got, exp);
    endtask : near
    // expected count after a load, cyc idle cycles, ratio 2^p
    function automatic logic [7:0] exp_count(input logic [7:0] start,
        input int cyc, input int p);
        exp_count = start - 8'((cyc + 1) >> p);
    endfunction : exp_count
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // ******
    // main sequence
    // ******
    initial
    begin
        {rst_n, regWr, regRd, timerPin, intClkEn, stopMode, stopWake} = 0;
        {iBit, regAddr, regWdata, error_cnt, samples_checked} = 0;
        seed = 85;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h09, d);
        chk(d, 8'h44);
        rd(8'h08, d);
        chk(d, 8'hff);
        rd(8'h20, d);
        chk(d, 8'h00);
        // load then read back at once with no clock running
        wr(8'h08, 8'h5a);
        rd(8'h08, d);
        chk(d, 8'h5a);
        @(posedge mclk);
        intClkEn <= 1'b1;
        // every ratio, random preset and random wait
        for (int p = 0; p < 8; p++)
        begin
            c = 8'h80 | 8'($random(seed));
            wr(8'h09, 8'h48 | 8'(p));
            wr(8'h08, c);
            r = $unsigned($random(seed)) % (16 << p);
            repeat (r) @(posedge mclk);
            rd(8'h08, d);
            near(d, exp_count(c, r, p));
        end
        // pass through zero with the request open
        wr(8'h09, 8'h08);
        wr(8'h08, 8'h02);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        chk({7'h0, timerReq}, 8'h01);
        rd(8'h08, d);
        near(d, 8'hfb);
        for (r = 0; r < 10 && svcCnt === 8'h00; r++)
            @(posedge mclk);
        chk({7'h0, svcCnt != 8'h00}, 8'h01);
        wr(8'h09, 8'hc0);
        @(negedge mclk);
        chk({7'h0, timerReq}, 8'h00);
        rd(8'h09, d);
        chk(d & 8'hc0, 8'hc0);
        wr(8'h09, 8'h40);
        rd(8'h09, d);
        chk(d & 8'hf8, 8'h40);
        // block interrupt raised, masked, cleared
        wr(8'h0b, 8'h01);
        @(negedge mclk);
        chk({7'h0, irq}, 8'h01);
        wr(8'h0b, 8'h00);
        wr(8'h0a, 8'h01);
        wr(8'h0b, 8'h01);
        @(negedge mclk);
        chk({7'h0, irq}, 8'h00);
        // halted sources with the pin low, then the pin alone
        for (int s = 1; s < 4; s++)
        begin
            wr(8'h09, 8'h40 | 8'(s << 4));
            rd(8'h08, d);
            repeat (8) @(posedge mclk);
            rd(8'h08, e);
            chk(e, d);
        end
        @(posedge mclk);
        timerPin <= 1'b1;
        intClkEn <= 1'b0;
        rd(8'h08, d);
        repeat (8) @(posedge mclk);
        rd(8'h08, e);
        near(e, d - 8'h0a);
        // stop holds the count; wake clears it and sets the flag
        wr(8'h09, 8'h40);
        intClkEn <= 1'b1;
        stopMode <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(8'h08, d);
        repeat (4) @(posedge mclk);
        rd(8'h08, e);
        chk(e, d);
        wr(8'h09, 8'h60);
        stopWake <= 1'b1;
        stopMode <= 1'b0;
        @(posedge mclk);
        stopWake <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(8'h08, d);
        chk(d, 8'h00);
        rd(8'h09, d);
        chk(d & 8'h80, 8'h80);
        // stop exit raises both status sources, mask still enables b0
        rd(8'h0a, d);
        chk(d, 8'h03);
        rd(8'h0b, d);
        chk(d, 8'h01);
        @(negedge mclk);
        chk({7'h0, irq}, 8'h01);
        end_sim();
    end
endmodule : tb_top
